// *** dv/dfed_cable_sva.sv ***
// concurrent checks on the drive cable between the two ends
`timescale 1ns/1ps
module dfed_cable_sva (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic read_gate,
    input wire logic write_gate,
    input wire logic seek_strobe,
    input wire logic rtz_seek,
    input wire logic [9:0] cyl_addr,
    input wire logic [2:0] tag_code,
    input wire logic [7:0] status_byte,
    input wire logic fault,
    input wire logic seek_error,
    input wire logic unit_ready,
    input wire logic on_cylinder
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);
    property p_not_ready;
        fault |-> !unit_ready;
    endproperty
    a_not_ready: assert property (p_not_ready) else $error("ready with fault");
    property p_check_bit;
        tag_code[2:1] == 2'h3 && (fault || seek_error) |=> status_byte[7];
    endproperty
    a_check_bit: assert property (p_check_bit) else $error("check bit low");
    property p_both_gates;
        !(read_gate && write_gate);
    endproperty
    a_both_gates: assert property (p_both_gates) else $error("both gates raised");
    property p_gate_off_cyl;
        (read_gate || write_gate) && !on_cylinder |=> fault && !read_gate && !write_gate;
    endproperty
    a_gate_off_cyl: assert property (p_gate_off_cyl) else $error("no fault off cyl");
    property p_seek_hold;
        seek_error && !rtz_seek |=> seek_error;
    endproperty
    a_seek_hold: assert property (p_seek_hold) else $error("seek error lost");
    property p_rtz_clear;
        rtz_seek |-> ##[1:2] !seek_error;
    endproperty
    a_rtz_clear: assert property (p_rtz_clear) else $error("seek error kept");
    property p_bad_cyl;
        seek_strobe && cyl_addr > dfed_pkg::max_cyl_large |-> ##[1:2] seek_error;
    endproperty
    a_bad_cyl: assert property (p_bad_cyl) else $error("bad cylinder taken");
    property p_freg_tag;
        fault && tag_code == dfed_pkg::tag_err_recovery |=> |status_byte[dfed_pkg::fr_w-1:0];
    endproperty
    a_freg_tag: assert property (p_freg_tag) else $error("fault bit missing");
    c_seek_err: cover property ($rose(seek_error));
    c_rtz: cover property (seek_error && rtz_seek);
    c_check: cover property (tag_code == dfed_pkg::tag_control && seek_error);
endmodule

// *** dv/tb_drive_fault_error_detection.sv ***
// self-checking bench for both ends of the drive cable
`timescale 1ns/1ps
module tb_drive_fault_error_detection;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] rdata;
    logic [4:0] mon = 5'h0;
    logic speed_low = 1'b0;
    logic servo_dibit = 1'b0;
    logic on_cyl_sense = 1'b1;
    logic eot_fwd = 1'b0;
    logic eot_rev = 1'b0;
    logic load_start = 1'b0;
    logic op_sw = 1'b0;
    logic maint_sw = 1'b0;
    logic fault_lamp, rtz_logic, retract, wr_en, ld_en, seek_go;
    logic [15:0] v;
    logic [9:0] cyl;
    integer seed = 32'h4cec;
    int n_errors = 0;
    int check_count = 0;
    int n_seeks = 0;
    int s0;
    dfed_if link_a();
    dfed_if link_b();
    dfed_ctrl u_dfed_ctrl (.mclk(mclk), .rstn(rstn), .link(link_a.ctrl), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
    dfed_drive #(.no_servo_cycles(20), .seek_cycles(20)) u_dfed_drive (.mclk(mclk),
        .rstn(rstn), .link(link_a.drive), .wr_drv_out_low(mon[0]), .wr_drv_cur_low(mon[1]),
        .wr_supply_low(mon[2]), .multi_head_sel(mon[3]), .rail_low(mon[4]),
        .speed_low(speed_low), .servo_dibit(servo_dibit), .on_cyl_sense(on_cyl_sense),
        .eot_fwd(eot_fwd), .eot_rev(eot_rev), .load_start(load_start),
        .operator_fault_sw(op_sw), .maint_clear_sw(maint_sw), .fault_lamp(fault_lamp),
        .return_to_zero_logic(rtz_logic), .emergency_retract(retract),
        .write_enable(wr_en), .load_enable(ld_en), .seek_start(seek_go));
    dfed_drive #(.no_servo_cycles(20), .seek_cycles(20), .small_model(1'b1)) u_dfed_drive_b
        (.mclk(mclk),
        .rstn(rstn), .link(link_b.drive), .wr_drv_out_low(mon[0]), .wr_drv_cur_low(mon[1]),
        .wr_supply_low(mon[2]), .multi_head_sel(mon[3]), .rail_low(mon[4]),
        .speed_low(speed_low), .servo_dibit(servo_dibit), .on_cyl_sense(on_cyl_sense),
        .eot_fwd(eot_fwd), .eot_rev(eot_rev), .load_start(load_start),
        .operator_fault_sw(op_sw), .maint_clear_sw(maint_sw), .fault_lamp(),
        .return_to_zero_logic(), .emergency_retract(), .write_enable(), .load_enable(),
        .seek_start());
    dfed_cable_sva u_dfed_cable_sva (.mclk(mclk), .rstn(rstn), .read_gate(link_a.read_gate),
        .write_gate(link_a.write_gate), .seek_strobe(link_a.seek_strobe),
        .rtz_seek(link_a.rtz_seek), .cyl_addr(link_a.cyl_addr), .tag_code(link_a.tag_code),
        .status_byte(link_a.status_byte), .fault(link_a.fault),
        .seek_error(link_a.seek_error), .unit_ready(link_a.unit_ready),
        .on_cylinder(link_a.on_cylinder));
    always #20 mclk = ~mclk;
    always @(posedge mclk)
        if (seek_go === 1'b1)
            n_seeks++;
    // ----------------------------------------
    // tasks and expectations
    // ----------------------------------------
    function automatic logic [15:0] freg_of(input int k);
        return 16'h1 << (k < 3 ? dfed_pkg::fr_write : k == 3 ? dfed_pkg::fr_multi_sel
            : dfed_pkg::fr_voltage);
    endfunction
    function automatic logic [15:0] b_exp(input int c);
        return c == 0 ? 16'h5 : c == 1 ? 16'h8 : c == 2 ? 16'h1 : 16'h0;
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [15:0] q);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 q = rdata;
    endtask
    task automatic tag_rd(input logic [2:0] t, output logic [15:0] q);
        wr_reg(dfed_pkg::reg_tag, {13'h0, t});
        repeat (2) @(posedge mclk);
        rd_reg(dfed_pkg::reg_tag_data, q);
    endtask
    task automatic cmd(input int b);
        wr_reg(dfed_pkg::reg_ctrl, 16'h1 << b);
        repeat (4) @(posedge mclk);
    endtask
    // clears: 0 operator switch, 1 maintenance switch, 2 controller
    task automatic clr(input int how);
        if (how == 2)
            cmd(dfed_pkg::ctl_fault_clear);
        else
        begin
            @(posedge mclk);
            op_sw <= (how == 0);
            maint_sw <= (how == 1);
            repeat (3) @(posedge mclk);
            op_sw <= 1'b0;
            maint_sw <= 1'b0;
            repeat (4) @(posedge mclk);
        end
    endtask
    task automatic results;
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        results();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        {link_b.read_gate, link_b.write_gate, link_b.write_data} = 3'h0;
        {link_b.fault_clear, link_b.seek_strobe, link_b.rtz_seek} = 3'h0;
        link_b.cyl_addr = 10'h0;
        link_b.tag_code = dfed_pkg::tag_err_recovery;
        link_b.tag_strobe = 1'b1;
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        repeat (3) @(posedge mclk);
        for (int i = 0; i < 14; i++)
        begin
            cyl = i == 0 ? 10'h336 : i == 1 ? 10'h337 : 10'($random(seed));
            s0 = n_seeks;
            wr_reg(dfed_pkg::reg_cyl, {6'h0, cyl});
            cmd(dfed_pkg::ctl_seek);
            rd_reg(dfed_pkg::reg_status, v);
            chk(v & 16'h2, {14'h0, cyl > 10'h336, 1'b0});
            chk(16'(n_seeks - s0), {15'h0, cyl <= 10'h336});
            chk(v & 16'h4, 16'h4);
            rd_reg(dfed_pkg::reg_cyl, v);
            chk(v, {6'h0, cyl});
            if (cyl > 10'h336)
            begin
                wr_reg(dfed_pkg::reg_cyl, 16'h5);
                cmd(dfed_pkg::ctl_seek);
                chk(16'(n_seeks - s0), 16'h0);
                tag_rd(dfed_pkg::tag_low_cyl, v);
                chk(v & 16'h80, 16'h80);
                tag_rd(dfed_pkg::tag_control, v);
                chk(v & 16'h80, 16'h80);
                cmd(dfed_pkg::ctl_rtz);
                rd_reg(dfed_pkg::reg_status, v);
                chk(v & 16'h2, 16'h0);
            end
        end
        on_cyl_sense <= 1'b0;
        cmd(dfed_pkg::ctl_seek);
        rd_reg(dfed_pkg::reg_status, v);
        chk(v & 16'h2, 16'h0);
        chk(v & 16'h14, 16'h0);
        repeat (25) @(posedge mclk);
        rd_reg(dfed_pkg::reg_status, v);
        chk(v & 16'h2, 16'h2);
        on_cyl_sense <= 1'b1;
        repeat (3) @(posedge mclk);
        cmd(dfed_pkg::ctl_rtz);
        for (int e = 0; e < 2; e++)
        begin
            eot_fwd <= (e == 0);
            eot_rev <= (e == 1);
            repeat (4) @(posedge mclk);
            {eot_fwd, eot_rev} <= 2'h0;
            repeat (4) @(posedge mclk);
            rd_reg(dfed_pkg::reg_status, v);
            chk(v & 16'h2, 16'h2);
            cmd(dfed_pkg::ctl_rtz);
        end
        for (int k = 0; k < 5; k++)
        begin
            mon <= 5'h1 << k;
            repeat (6) @(posedge mclk);
            chk({15'h0, retract}, {15'h0, k == 4});
            clr(k % 3);
            rd_reg(dfed_pkg::reg_status, v);
            chk(v & 16'h1, 16'h1);
            chk(v & 16'h4, 16'h0);
            mon <= 5'h0;
            repeat (4) @(posedge mclk);
            tag_rd(k[0] ? dfed_pkg::tag_diagnostic : dfed_pkg::tag_err_recovery, v);
            chk(v & 16'h1f, freg_of(k));
            chk({15'h0, fault_lamp}, 16'h1);
            chk({15'h0, wr_en}, 16'h0);
            clr(k % 2 == 0 ? 2 : 0);
            rd_reg(dfed_pkg::reg_status, v);
            chk(v & 16'h1, 16'h0);
            tag_rd(dfed_pkg::tag_diagnostic, v);
            chk(v & 16'h1f, freg_of(k));
            clr(1);
            tag_rd(dfed_pkg::tag_err_recovery, v);
            chk(v & 16'h1f, 16'h0);
        end
        speed_low <= 1'b1;
        repeat (5) @(posedge mclk);
        rd_reg(dfed_pkg::reg_status, v);
        chk(v & 16'h9, 16'h8);
        chk({retract, wr_en}, 16'h2);
        speed_low <= 1'b0;
        load_start <= 1'b1;
        repeat (8) @(posedge mclk);
        chk({15'h0, rtz_logic}, 16'h0);
        repeat (25) @(posedge mclk);
        chk({rtz_logic, fault_lamp, ld_en}, 16'h6);
        load_start <= 1'b0;
        clr(2);
        chk({15'h0, rtz_logic}, 16'h0);
        servo_dibit <= 1'b1;
        load_start <= 1'b1;
        repeat (40) @(posedge mclk);
        chk({rtz_logic, ld_en}, 16'h1);
        load_start <= 1'b0;
        // controller gates: never both, only on cylinder, dropped when off
        wr_reg(dfed_pkg::reg_ctrl, 16'h3);
        rd_reg(dfed_pkg::reg_ctrl, v);
        chk(v, 16'h0);
        wr_reg(dfed_pkg::reg_ctrl, 16'h1);
        rd_reg(dfed_pkg::reg_ctrl, v);
        chk(v, 16'h1);
        on_cyl_sense <= 1'b0;
        repeat (4) @(posedge mclk);
        rd_reg(dfed_pkg::reg_ctrl, v);
        chk(v, 16'h0);
        chk({15'h0, link_a.fault}, 16'h1);
        on_cyl_sense <= 1'b1;
        for (int c = 0; c < 4; c++)
        begin
            clr(1);
            on_cyl_sense <= (c != 1);
            repeat (4) @(posedge mclk);
            link_b.read_gate <= (c < 2);
            link_b.write_gate <= (c != 1);
            repeat (6) @(posedge mclk)
                link_b.write_data <= (c == 3) ? ~link_b.write_data : 1'b0;
            {link_b.read_gate, link_b.write_gate} <= 2'h0;
            on_cyl_sense <= 1'b1;
            repeat (4) @(posedge mclk);
            chk({8'h0, link_b.status_byte & 8'h1f}, b_exp(c));
            chk({15'h0, link_b.fault}, {15'h0, c < 3});
        end
        // small model limit on the second drive
        for (int m = 0; m < 2; m++)
        begin
            link_b.cyl_addr <= m ? 10'h19b : 10'h19a;
            link_b.rtz_seek <= 1'b1;
            @(posedge mclk);
            link_b.rtz_seek <= 1'b0;
            link_b.seek_strobe <= 1'b1;
            @(posedge mclk);
            link_b.seek_strobe <= 1'b0;
            repeat (2) @(posedge mclk);
            chk({15'h0, link_b.seek_error}, {15'h0, m == 1});
        end
        results();
    end
endmodule

// *** hdl/dfed_ctrl.sv ***
// controller end: drives the cable from software registers
`timescale 1ns/1ps
module dfed_ctrl (
    input wire logic mclk,
    input wire logic rstn,
    dfed_if.ctrl link,
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata
);
    logic [1:0] gate_q;
    logic [9:0] cyl_q;
    logic [2:0] tag_q;
    logic [2:0] pulse_q;
    logic [15:0] rdata_q;
    logic [15:0] rmux;
    logic wr_ctrl;
    logic [1:0] gate_d;
    assign wr_ctrl = wr & (addr == dfed_pkg::reg_ctrl);
    // gates are never raised together, nor while off cylinder
    assign gate_d[0] = wdata[dfed_pkg::ctl_read_gate] & ~wdata[dfed_pkg::ctl_write_gate]
        & link.on_cylinder;
    assign gate_d[1] = wdata[dfed_pkg::ctl_write_gate] & ~wdata[dfed_pkg::ctl_read_gate]
        & link.on_cylinder;
    assign rmux = (addr == dfed_pkg::reg_ctrl) ? {14'h0000, gate_q} :
        (addr == dfed_pkg::reg_cyl) ? {6'h00, cyl_q} :
        (addr == dfed_pkg::reg_tag) ? {13'h0000, tag_q} :
        (addr == dfed_pkg::reg_status) ? {11'h000, link.on_cylinder, link.write_protect,
            link.unit_ready, link.seek_error, link.fault} :
        (addr == dfed_pkg::reg_tag_data) ? {8'h00, link.status_byte} : 16'h0000;
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            gate_q <= 2'h0;
            cyl_q <= 10'h000;
            tag_q <= 3'h0;
            pulse_q <= 3'h0;
            rdata_q <= 16'h0000;
        end
        else
        begin
            gate_q <= wr_ctrl ? gate_d : (gate_q & {2{link.on_cylinder}});
            if (wr & (addr == dfed_pkg::reg_cyl))
                cyl_q <= wdata[9:0];
            if (wr & (addr == dfed_pkg::reg_tag))
                tag_q <= wdata[2:0];
            pulse_q <= wr_ctrl ? {wdata[dfed_pkg::ctl_rtz], wdata[dfed_pkg::ctl_seek],
                wdata[dfed_pkg::ctl_fault_clear]} : 3'h0;
            rdata_q <= rd ? rmux : 16'h0000;
        end
    end
    assign link.read_gate = gate_q[0];
    assign link.write_gate = gate_q[1];
    assign link.write_data = 1'b0;
    assign link.fault_clear = pulse_q[0];
    assign link.seek_strobe = pulse_q[1];
    assign link.rtz_seek = pulse_q[2];
    assign link.cyl_addr = cyl_q;
    assign link.tag_code = tag_q;
    assign link.tag_strobe = 1'b1;
    assign rdata = rdata_q;
endmodule

// *** hdl/dfed_drive.sv ***
// drive end: fault latch, fault register, servo and seek error detection
`timescale 1ns/1ps
// What this block does
// - each fault also sets its register latch
// - register latches show on tags 001, 010
// - register clears only on maintenance or power-down
// - low driver output, current or supply: write fault
// - write gate without data transitions: write fault
// - multiple heads selected raises fault
// - read and write gates together: fault
// - gate while off cylinder: fault
// - low supply rail sets voltage fault
// - low speed/voltage: signal, retract; low speed sets no latch
// - speed/voltage fault disables write, asserts protect
// - no dibits 350 ms after load: latch
// - no-servo latch lights fault, unloads, blocks load
// - no-servo latch clears like fault latch
// - no on-cylinder 500 ms after seek: error
// - end-of-travel sensor sets seek error
// - cylinder above 822 (410) sets seek error
// - seek error asserts line, refuses seeks
// - seek error forces bit 7 on 110, 111
// - return-to-zero seek clears seek error
// - fault latch: line, lamp, not ready, inhibit, bit 7
// - fault latch clears on a clear request once conditions gone
module dfed_drive #(
    parameter int unsigned no_servo_cycles = dfed_pkg::no_servo_cycles,
    parameter int unsigned seek_cycles = dfed_pkg::seek_cycles,
    parameter bit small_model = 1'b0
) (
    input wire logic mclk,
    input wire logic rstn,
    dfed_if.drive link,
    input wire logic wr_drv_out_low,
    input wire logic wr_drv_cur_low,
    input wire logic wr_supply_low,
    input wire logic multi_head_sel,
    input wire logic rail_low,
    input wire logic speed_low,
    input wire logic servo_dibit,
    input wire logic on_cyl_sense,
    input wire logic eot_fwd,
    input wire logic eot_rev,
    input wire logic load_start,
    input wire logic operator_fault_sw,
    input wire logic maint_clear_sw,
    output logic fault_lamp,
    output logic return_to_zero_logic,
    output logic emergency_retract,
    output logic write_enable,
    output logic load_enable,
    output logic seek_start
);
    localparam int unsigned mon_w = 14;
    localparam int unsigned cnt_w = 32;
    logic [mon_w-1:0] mon_raw;
    logic [mon_w-1:0] mon;
    logic s_drv_out, s_drv_cur, s_supply, s_multi, s_rail, s_speed, s_dibit, s_oncyl;
    logic s_eot_f, s_eot_r, s_load, s_op_sw, s_maint, s_wdata;
    // ----------------------------------------------------------------
    // monitor synchronisers
    // ----------------------------------------------------------------
    assign mon_raw = {wr_drv_out_low, wr_drv_cur_low, wr_supply_low, multi_head_sel,
        rail_low, speed_low, servo_dibit, on_cyl_sense, eot_fwd, eot_rev, load_start,
        operator_fault_sw, maint_clear_sw, link.write_data};
    dfed_sync #(.width(mon_w)) u_sync
    (
        .mclk(mclk),
        .rstn(rstn),
        .async_in(mon_raw),
        .sync_out(mon)
    );
    assign {s_drv_out, s_drv_cur, s_supply, s_multi, s_rail, s_speed, s_dibit, s_oncyl,
        s_eot_f, s_eot_r, s_load, s_op_sw, s_maint, s_wdata} = mon;
    // ----------------------------------------------------------------
    // fault causes
    // ----------------------------------------------------------------
    logic wdata_q;
    logic wdata_seen_q, wdata_seen_d;
    logic gate_q;
    logic no_wdata;
    logic [dfed_pkg::fr_w-1:0] cause;
    logic any_cause;
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            wdata_q <= 1'b0;
            wdata_seen_q <= 1'b0;
            gate_q <= 1'b0;
        end
        else
        begin
            wdata_q <= s_wdata;
            wdata_seen_q <= wdata_seen_d;
            gate_q <= link.write_gate;
        end
    end
    // a transition window spans the active write gate; checked when the gate drops
    assign wdata_seen_d = link.write_gate & (wdata_seen_q | (s_wdata ^ wdata_q));
    assign no_wdata = gate_q & ~link.write_gate & ~wdata_seen_q;
    assign cause[dfed_pkg::fr_write] = s_drv_out | s_drv_cur | s_supply | no_wdata;
    assign cause[dfed_pkg::fr_multi_sel] = s_multi;
    assign cause[dfed_pkg::fr_rd_wr] = link.read_gate & link.write_gate;
    assign cause[dfed_pkg::fr_off_cyl] = (link.read_gate | link.write_gate) & ~s_oncyl;
    assign cause[dfed_pkg::fr_voltage] = s_rail;
    assign any_cause = |cause;
    // ----------------------------------------------------------------
    // fault latch and fault register
    // ----------------------------------------------------------------
    logic fault_q;
    logic [dfed_pkg::fr_w-1:0] freg_q;
    logic fault_clr;
    assign fault_clr = (link.fault_clear | s_op_sw | s_maint) & ~any_cause;
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            fault_q <= 1'b0;
            freg_q <= '0;
        end
        else
        begin
            fault_q <= any_cause | (fault_q & ~fault_clr);
            // set wins over the maintenance clear
            freg_q <= cause | (freg_q & ~{dfed_pkg::fr_w{s_maint}});
        end
    end
    // ----------------------------------------------------------------
    // no-servo-tracks timer and latch
    // ----------------------------------------------------------------
    logic [cnt_w-1:0] ns_cnt_q;
    logic ns_run_q;
    logic ns_q;
    logic ns_expire;
    logic load_go;
    assign load_go = s_load & ~fault_q & ~ns_q & ~s_speed;
    assign ns_expire = ns_run_q & (ns_cnt_q == cnt_w'(no_servo_cycles - 1));
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            ns_cnt_q <= '0;
            ns_run_q <= 1'b0;
            ns_q <= 1'b0;
        end
        else
        begin
            ns_run_q <= (ns_run_q | load_go) & ~s_dibit & ~ns_expire;
            ns_cnt_q <= (ns_run_q & ~s_dibit) ? ns_cnt_q + cnt_w'(1) : '0;
            ns_q <= ns_expire | (ns_q & ~fault_clr);
        end
    end
    // ----------------------------------------------------------------
    // seek timer and seek error latch
    // ----------------------------------------------------------------
    logic [cnt_w-1:0] sk_cnt_q;
    logic sk_run_q;
    logic se_q;
    logic sk_expire;
    logic cyl_bad;
    logic seek_go;
    logic se_set;
    assign cyl_bad = link.seek_strobe & (link.cyl_addr >
        (small_model ? dfed_pkg::max_cyl_small : dfed_pkg::max_cyl_large));
    assign seek_go = link.seek_strobe & ~se_q & ~cyl_bad & ~fault_q;
    assign sk_expire = sk_run_q & ~s_oncyl
        & (sk_cnt_q == cnt_w'(seek_cycles - 1));
    assign se_set = sk_expire | s_eot_f | s_eot_r | cyl_bad;
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            sk_cnt_q <= '0;
            sk_run_q <= 1'b0;
            se_q <= 1'b0;
        end
        else
        begin
            sk_run_q <= seek_go | (sk_run_q & ~s_oncyl & ~sk_expire);
            sk_cnt_q <= seek_go ? '0 : (sk_run_q ? sk_cnt_q + cnt_w'(1) : sk_cnt_q);
            se_q <= se_set | (se_q & ~link.rtz_seek);
        end
    end
    // ----------------------------------------------------------------
    // status bytes
    // ----------------------------------------------------------------
    logic [7:0] status_q;
    logic [7:0] status_d;
    logic diag;
    assign diag = fault_q | se_q;
    always_comb
    begin
        status_d = 8'h00;
        case (link.tag_code)
            dfed_pkg::tag_err_recovery, dfed_pkg::tag_diagnostic:
                status_d[dfed_pkg::fr_w-1:0] = freg_q;
            dfed_pkg::tag_low_cyl, dfed_pkg::tag_control:
                status_d[dfed_pkg::check_diag_bit] = diag;
            default:
                status_d = 8'h00;
        endcase
    end
    always_ff @(posedge mclk)
    begin
        if (!rstn)
            status_q <= 8'h00;
        else if (link.tag_strobe)
            status_q <= status_d;
    end
    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign link.status_byte = status_q;
    assign link.fault = fault_q;
    assign link.seek_error = se_q;
    assign link.unit_ready = ~fault_q & s_oncyl;
    assign link.write_protect = s_speed | s_rail;
    assign link.on_cylinder = s_oncyl;
    assign fault_lamp = fault_q | ns_q;
    assign return_to_zero_logic = ns_q;
    assign emergency_retract = s_speed | s_rail;
    assign write_enable = ~fault_q & ~s_speed & ~s_rail;
    assign load_enable = load_go;
    assign seek_start = seek_go;
endmodule

// *** hdl/dfed_if.sv ***
// drive interface cable between controller and drive
`timescale 1ns/1ps
interface dfed_if;
    logic read_gate;
    logic write_gate;
    logic write_data;
    logic fault_clear;
    logic seek_strobe;
    logic rtz_seek;
    logic [9:0] cyl_addr;
    logic [2:0] tag_code;
    logic tag_strobe;
    logic [7:0] status_byte;
    logic fault;
    logic seek_error;
    logic unit_ready;
    logic write_protect;
    logic on_cylinder;
    modport drive
    (
        input read_gate, write_gate, write_data, fault_clear, seek_strobe, rtz_seek,
        input cyl_addr, tag_code, tag_strobe,
        output status_byte, fault, seek_error, unit_ready, write_protect, on_cylinder
    );
    modport ctrl
    (
        output read_gate, write_gate, write_data, fault_clear, seek_strobe, rtz_seek,
        output cyl_addr, tag_code, tag_strobe,
        input status_byte, fault, seek_error, unit_ready, write_protect, on_cylinder
    );
endinterface

// *** hdl/dfed_pkg.sv ***
// shared constants for the drive fault and error detection block
package dfed_pkg;
    localparam int unsigned clk_hz = 25000000;
    localparam int unsigned no_servo_ms = 350;
    localparam int unsigned seek_ms = 500;
    localparam int unsigned no_servo_cycles = (clk_hz / 1000) * no_servo_ms;
    localparam int unsigned seek_cycles = (clk_hz / 1000) * seek_ms;
    localparam logic [9:0] max_cyl_large = 10'h336;
    localparam logic [9:0] max_cyl_small = 10'h19a;
    localparam int unsigned cyl_w = 10;
    // tag codes
    localparam logic [2:0] tag_err_recovery = 3'h1;
    localparam logic [2:0] tag_diagnostic = 3'h2;
    localparam logic [2:0] tag_low_cyl = 3'h6;
    localparam logic [2:0] tag_control = 3'h7;
    // fault register bit positions
    localparam int unsigned fr_write = 0;
    localparam int unsigned fr_multi_sel = 1;
    localparam int unsigned fr_rd_wr = 2;
    localparam int unsigned fr_off_cyl = 3;
    localparam int unsigned fr_voltage = 4;
    localparam int unsigned fr_w = 5;
    localparam int unsigned check_diag_bit = 7;
    // controller register map
    localparam logic [3:0] reg_ctrl = 4'h0;
    localparam logic [3:0] reg_cyl = 4'h1;
    localparam logic [3:0] reg_tag = 4'h2;
    localparam logic [3:0] reg_status = 4'h3;
    localparam logic [3:0] reg_tag_data = 4'h4;
    localparam int unsigned ctl_read_gate = 0;
    localparam int unsigned ctl_write_gate = 1;
    localparam int unsigned ctl_fault_clear = 2;
    localparam int unsigned ctl_seek = 3;
    localparam int unsigned ctl_rtz = 4;
    localparam int unsigned ctl_tag_strobe = 5;
endpackage

// *** hdl/dfed_sync.sv ***
// two-stage synchroniser for a bundle of asynchronous levels
`timescale 1ns/1ps
module dfed_sync #(
    parameter int unsigned width = 1
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [width-1:0] async_in,
    output logic [width-1:0] sync_out
);
    logic [width-1:0] meta_q;
    logic [width-1:0] sync_q;
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end
    assign sync_out = sync_q;
endmodule
